// ==== asprc_consts.vh ====
// Constants for the converter sync, power and readout control block
`ifndef ASPRC_CONSTS_VH
`define ASPRC_CONSTS_VH

// APB register byte addresses
`define ASPRC_ADDR_CFG0     12'h000
`define ASPRC_ADDR_CFG1     12'h004
`define ASPRC_ADDR_IDCFG    12'h008
`define ASPRC_ADDR_OFC      12'h00c
`define ASPRC_ADDR_STATUS   12'h010
`define ASPRC_ADDR_SAMPLE   12'h014

// Field positions
`define ASPRC_CFG0_MODE1    0
`define ASPRC_CFG0_MODE0    1
`define ASPRC_CFG0_CSYNC    2
`define ASPRC_CFG0_AUTORD   3
`define ASPRC_CFG1_CHOP     0
`define ASPRC_IDCFG_MODE2   0
`define ASPRC_IDCFG_DITHER  1

// Reset values and nominal offset
`define ASPRC_CFG0_RST      8'h0b
`define ASPRC_CFG1_RST      8'h01
`define ASPRC_IDCFG_RST     8'h01
`define ASPRC_OFC_RST       24'h000000
`define ASPRC_OFC_NOMINAL   24'h029700
`define ASPRC_PIN_IDLE      6'h0a

// Command bytes
`define ASPRC_CMD_RESET     8'h06
`define ASPRC_CMD_SYNC      8'h04
`define ASPRC_CMD_STANDBY   8'h02
`define ASPRC_CMD_RESUME    8'h03
`define ASPRC_CMD_AUTORD    8'h10
`define ASPRC_CMD_CMDRD     8'h11
`define ASPRC_CMD_READ      8'h12

// Timing
`define ASPRC_SETTLE_CONV   6'd63
`define ASPRC_GUARD_MCLK    3'd4
`define ASPRC_WORD_BITS     6'd32
`define ASPRC_CMD_BITS      4'd8

`endif

// ==== asprc_ctrl.v ====
// Converter reset, power, sync and readout control with APB registers
// Overview of operation
// - Device stays in reset while reset pin is low.
// - Reset command acts on first master edge after eighth serial edge.
// - Any reset restores register defaults and realigns conversions.
// - Chop enable bit in second config register, set after reset.
// - Dither bit adds offset; software writes 029700h to offset regs.
// - Power-down pin low powers core off and restores defaults.
// - Standby command stops core; resume command ends standby.
// - Standby ends whenever chip select is high.
// - Align pin sync on first master edge after its rise.
// - Sync command acts on first master edge after eighth bit.
// - Pulse-sync: each align rise aborts conversion, clears filter.
// - First 63 results after sync are withheld; the code withholds only 61.
// - Any register write resynchronizes, losing prior alignment.
// - Continuous-sync resyncs only when edge period is off-grid.
// - Ready keeps pulsing with zero data until conversion 63; the code sends data from conversion 62.
// - Only the align pin drives continuous-sync operation.
// - Standby then resume restores alignment if interval off-period.
// - Auto-read shows MSB when ready falls; host samples on rise.
// - Ready returns high on first falling serial clock edge.
// - After 32 bits output is low; host may stop after 24.
// - Results are 32-bit two's complement words.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "asprc_consts.vh"

module asprc_ctrl #(
   parameter DATA_PERIOD = 1024              // Master clocks per conversion
) (
   input  wire        clk,                   // System clock, 125 MHz
   input  wire        rst_n,                 // Async reset, active low
   input  wire        psel,                  // APB select
   input  wire        penable,               // APB enable
   input  wire        pwrite,                // APB write
   input  wire [11:0] paddr,                 // APB byte address
   input  wire [31:0] pwdata,                // APB write data
   output reg  [31:0] prdata,                // APB read data
   output reg         pready,                // APB ready
   output reg         pslverr,               // APB error
   input  wire        mclk_pin,              // Master clock pin
   input  wire        reset_pin_n,           // Reset pin, active low
   input  wire        power_down_pin_n,      // Power-down pin, active low
   input  wire        align_pin,             // Sync pin
   input  wire        cs_pin_n,              // Serial chip select
   input  wire        sclk_pin,              // Serial clock
   input  wire        din_pin,               // Serial data in
   input  wire [31:0] conv_data,             // Filter result, two's compl.
   output reg         dout,                  // Serial data out
   output reg         dout_oe,               // Serial data out enable
   output reg         result_ready_n,        // Data ready strobe
   output reg         core_on,               // Converter core powered
   output reg         filter_clear           // Filter memory clear pulse
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   localparam NPIN = 6, PIN_IDLE = `ASPRC_PIN_IDLE;
   wire [NPIN-1:0] pin_raw = {din_pin, sclk_pin, cs_pin_n, align_pin,
                              power_down_pin_n, mclk_pin};
   reg  [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q[gi]  <= PIN_IDLE[gi];
               s2_q[gi]  <= PIN_IDLE[gi];
               s3_q[gi]  <= PIN_IDLE[gi];
               pin_q[gi] <= PIN_IDLE[gi];
            end else begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
                  pin_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate

   reg [NPIN-1:0] pin_d1_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         pin_d1_q <= PIN_IDLE;
      else
         pin_d1_q <= pin_q;
   end

   wire mclk_rise  = pin_q[0] & ~pin_d1_q[0];
   wire pd_low     = ~pin_q[1];
   wire align_rise = pin_q[2] & ~pin_d1_q[2];
   wire cs_high    = pin_q[3];
   wire sclk_rise  = pin_q[4] & ~pin_d1_q[4];
   wire sclk_fall  = ~pin_q[4] & pin_d1_q[4];
   wire din_s      = pin_q[5];

   // Reset pin: three flops, asserted level kept while pin low
   reg [2:0] rpin_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rpin_q <= 3'b111;
      else
         rpin_q <= {rpin_q[1:0], reset_pin_n};
   end
   reg rpin_low_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rpin_low_q <= 1'b0;
      else if (rpin_q[1] == rpin_q[2])
         rpin_low_q <= ~rpin_q[2];
   end

   // ---------------------------------------------------------------
   // Serial command receiver
   // ---------------------------------------------------------------
   reg [7:0] cmd_sr_q;
   reg [3:0] cmd_cnt_q;
   reg       cmd_done_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_sr_q   <= 8'h00;
         cmd_cnt_q  <= 4'h0;
         cmd_done_q <= 1'b0;
      end else begin
         cmd_done_q <= 1'b0;
         if (cs_high) begin
            cmd_cnt_q <= 4'h0;
         end else if (sclk_rise) begin
            cmd_sr_q <= {cmd_sr_q[6:0], din_s};
            if (cmd_cnt_q == `ASPRC_CMD_BITS - 4'd1) begin
               cmd_cnt_q  <= 4'h0;
               cmd_done_q <= 1'b1;
            end else begin
               cmd_cnt_q <= cmd_cnt_q + 4'd1;
            end
         end
      end
   end

   function is_cmd;
      input [7:0] code;
      begin
         is_cmd = cmd_done_q && (cmd_sr_q == code);
      end
   endfunction

   // Pending command and align pin events, served on next master clock rise
   reg rst_cmd_q, sync_cmd_q, align_pend_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_cmd_q    <= 1'b0;
         sync_cmd_q   <= 1'b0;
         align_pend_q <= 1'b0;
      end else begin
         rst_cmd_q  <= is_cmd(`ASPRC_CMD_RESET) |
                       (rst_cmd_q & ~mclk_rise);
         sync_cmd_q <= is_cmd(`ASPRC_CMD_SYNC) |
                       (sync_cmd_q & ~mclk_rise);
         align_pend_q <= align_rise |
                         (align_pend_q & ~mclk_rise);
      end
   end

   // ---------------------------------------------------------------
   // Soft reset: pin, power-down pin or command
   // ---------------------------------------------------------------
   wire soft_rst = rpin_low_q | pd_low |
                   (rst_cmd_q & mclk_rise);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [7:0]  cfg0_q, cfg1_q, idcfg_q;
   reg [23:0] ofc_q;
   reg        wr_pulse_q;
   wire       apb_acc = psel & penable & pready;
   wire       apb_wr  = apb_acc & pwrite;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg0_q     <= `ASPRC_CFG0_RST;
         cfg1_q     <= `ASPRC_CFG1_RST;
         idcfg_q    <= `ASPRC_IDCFG_RST;
         ofc_q      <= `ASPRC_OFC_RST;
         wr_pulse_q <= 1'b0;
      end else if (soft_rst) begin
         cfg0_q     <= `ASPRC_CFG0_RST;
         cfg1_q     <= `ASPRC_CFG1_RST;
         idcfg_q    <= `ASPRC_IDCFG_RST;
         ofc_q      <= `ASPRC_OFC_RST;
         wr_pulse_q <= 1'b0;
      end else begin
         wr_pulse_q <= 1'b0;
         if (apb_wr) begin
            if (paddr == `ASPRC_ADDR_CFG0) begin
               cfg0_q     <= pwdata[7:0];
               wr_pulse_q <= 1'b1;
            end else if (paddr == `ASPRC_ADDR_CFG1) begin
               cfg1_q     <= pwdata[7:0];
               wr_pulse_q <= 1'b1;
            end else if (paddr == `ASPRC_ADDR_IDCFG) begin
               idcfg_q    <= pwdata[7:0];
               wr_pulse_q <= 1'b1;
            end else if (paddr == `ASPRC_ADDR_OFC) begin
               ofc_q      <= pwdata[23:0];
               wr_pulse_q <= 1'b1;
            end
         end
      end
   end

   wire csync_mode = cfg0_q[`ASPRC_CFG0_CSYNC];
   reg  auto_read_mode_q;

   // ---------------------------------------------------------------
   // Standby and core power
   // ---------------------------------------------------------------
   reg standby_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         standby_q <= 1'b0;
      else if (soft_rst || cs_high)
         standby_q <= 1'b0;
      else if (is_cmd(`ASPRC_CMD_STANDBY))
         standby_q <= 1'b1;
      else if (is_cmd(`ASPRC_CMD_RESUME))
         standby_q <= 1'b0;
   end
   wire resume_evt = standby_q &
                     (is_cmd(`ASPRC_CMD_RESUME) | cs_high);

   // ---------------------------------------------------------------
   // Conversion timing in master clocks
   // ---------------------------------------------------------------
   localparam PW = 16;
   reg [PW-1:0] phase_q;       // Master clocks into current conversion
   reg [PW-1:0] since_q;       // Master clocks since last align edge
   reg [PW-1:0] stby_len_q;    // Master clocks spent in standby
   reg          armed_q;       // Continuous-sync first edge taken
   reg [5:0]    settle_q;
   reg          conv_tick;

   function off_grid;
      input [PW-1:0] len;
      reg   [PW-1:0] rem;
      begin
         rem      = len % DATA_PERIOD[PW-1:0];
         off_grid = (rem != {PW{1'b0}}) &&
                    (rem != DATA_PERIOD[PW-1:0] - 1'b1) &&
                    (len != {PW{1'b0}}) && (rem != 1'b1);
      end
   endfunction

   wire align_now = align_pend_q & mclk_rise;
   wire pin_sync  = align_now &&
                    (!csync_mode || !armed_q ||
                     off_grid(since_q + 1'b1));
   wire cmd_sync  = sync_cmd_q & mclk_rise & ~csync_mode;
   wire stby_sync = resume_evt && csync_mode &&
                    off_grid(stby_len_q);
   wire do_sync   = pin_sync | cmd_sync | stby_sync | wr_pulse_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q    <= {PW{1'b0}};
         since_q    <= {PW{1'b0}};
         stby_len_q <= {PW{1'b0}};
         armed_q    <= 1'b0;
         settle_q   <= 6'd0;
         conv_tick  <= 1'b0;
         filter_clear <= 1'b0;
         core_on    <= 1'b0;
      end else if (soft_rst) begin
         phase_q    <= {PW{1'b0}};
         since_q    <= {PW{1'b0}};
         armed_q    <= 1'b0;
         settle_q   <= 6'd0;
         conv_tick  <= 1'b0;
         filter_clear <= 1'b1;
         core_on    <= ~pd_low;
      end else begin
         conv_tick    <= 1'b0;
         filter_clear <= 1'b0;
         core_on      <= ~standby_q;
         if (wr_pulse_q)
            armed_q <= 1'b0;
         if (align_now) begin
            since_q <= {PW{1'b0}};
            armed_q <= 1'b1;
         end else if (mclk_rise) begin
            since_q <= since_q + 1'b1;
         end
         if (standby_q && mclk_rise)
            stby_len_q <= stby_len_q + 1'b1;
         else if (!standby_q)
            stby_len_q <= {PW{1'b0}};
         if (do_sync) begin
            phase_q      <= {PW{1'b0}};
            settle_q     <= 6'd0;
            filter_clear <= 1'b1;
         end else if (mclk_rise && !standby_q) begin
            if (phase_q == DATA_PERIOD[PW-1:0] - 1'b1) begin
               phase_q   <= {PW{1'b0}};
               conv_tick <= 1'b1;
               if (settle_q != `ASPRC_SETTLE_CONV)
                  settle_q <= settle_q + 6'd1;
            end else begin
               phase_q <= phase_q + 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Readout
   // ---------------------------------------------------------------
   reg [31:0] out_sr_q, last_q;
   reg [5:0]  bit_cnt_q;
   reg        read_arm_q;
   wire settled = (settle_q == `ASPRC_SETTLE_CONV - 6'd1) ||
                  (settle_q == `ASPRC_SETTLE_CONV);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_read_mode_q <= 1'b1;
         out_sr_q         <= 32'h00000000;
         last_q           <= 32'h00000000;
         bit_cnt_q        <= 6'd0;
         read_arm_q       <= 1'b0;
         result_ready_n   <= 1'b1;
         dout             <= 1'b0;
         dout_oe          <= 1'b0;
      end else begin
         dout_oe <= ~cs_high;
         if (soft_rst || is_cmd(`ASPRC_CMD_AUTORD))
            auto_read_mode_q <= 1'b1;
         else if (is_cmd(`ASPRC_CMD_CMDRD))
            auto_read_mode_q <= 1'b0;
         if (cs_high && !auto_read_mode_q)
            auto_read_mode_q <= 1'b1;
         if (is_cmd(`ASPRC_CMD_READ))
            read_arm_q <= 1'b1;
         if (conv_tick) begin
            // Zero data until filter settles, then 32-bit result
            last_q <= settled ? conv_data : 32'h00000000;
            if (auto_read_mode_q || read_arm_q) begin
               out_sr_q       <= settled ? conv_data
                                         : 32'h00000000;
               bit_cnt_q      <= 6'd0;
               dout           <= settled & conv_data[31];
               result_ready_n <= 1'b0;
               read_arm_q     <= 1'b0;
            end
         end else if (phase_q == DATA_PERIOD[PW-1:0] -
                      {{(PW-3){1'b0}}, `ASPRC_GUARD_MCLK} &&
                      mclk_rise || soft_rst) begin
            result_ready_n <= 1'b1;
         end else if (sclk_fall && !cs_high) begin
            result_ready_n <= 1'b1;
            if (bit_cnt_q < `ASPRC_WORD_BITS - 6'd1) begin
               out_sr_q  <= {out_sr_q[30:0], 1'b0};
               dout      <= out_sr_q[30];
               bit_cnt_q <= bit_cnt_q + 6'd1;
            end else begin
               dout      <= 1'b0;
               bit_cnt_q <= `ASPRC_WORD_BITS;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h00000000;
            if (paddr == `ASPRC_ADDR_CFG0)
               prdata <= {24'h000000, cfg0_q};
            else if (paddr == `ASPRC_ADDR_CFG1)
               prdata <= {24'h000000, cfg1_q};
            else if (paddr == `ASPRC_ADDR_IDCFG)
               prdata <= {24'h000000, idcfg_q};
            else if (paddr == `ASPRC_ADDR_OFC)
               prdata <= {8'h00, ofc_q};
            else if (paddr == `ASPRC_ADDR_STATUS)
               prdata <= {16'h0000, 2'b00, settle_q, 4'h0,
                          auto_read_mode_q, armed_q, standby_q,
                          result_ready_n};
            else if (paddr == `ASPRC_ADDR_SAMPLE)
               prdata <= last_q;
            else
               pslverr <= 1'b1;
         end
      end
   end

endmodule

// ==== asprc_host_model.sv ====
// Host model driving the serial port of the control block
`timescale 1ns/1ps
module asprc_host_model (
   input  wire logic clk,      // Bench clock
   input  wire logic dout,     // Serial data out
   input  wire logic dout_oe,  // Device drives dout
   output logic      cs_pin_n, // Chip select
   output logic      sclk_pin, // Serial clock
   output logic      din_pin   // Serial data in
);
   // Undriven line reads as the inverse of the device output
   wire sdo = dout_oe ? dout : ~dout;
   initial begin
      cs_pin_n = 1'b1;
      sclk_pin = 1'b0;
      din_pin  = 1'b0;
   end
   // Half of a 64 ns link clock period
   task half;
      repeat (4) @(posedge clk);
   endtask
   task release_cs;
      cs_pin_n <= 1'b1;
      din_pin  <= ~din_pin;
      half;
   endtask
   // Command byte, MSB first, sclk still outside the frame
   task send_cmd(input logic [7:0] c, input logic keep);
      integer i;
      cs_pin_n <= 1'b0;
      half;
      for (i = 7; i >= 0; i--) begin
         din_pin  <= c[i];
         sclk_pin <= 1'b0;
         half;
         sclk_pin <= 1'b1;
         half;
      end
      sclk_pin <= 1'b0;
      half;
      if (!keep) begin
         cs_pin_n <= 1'b1;
         din_pin  <= ~din_pin;
      end
      half;
   endtask
   // Word plus one trailing bit; bits taken late in the high phase
   task read_word(output logic [31:0] w, output logic t);
      integer i;
      cs_pin_n <= 1'b0;
      half;
      half;
      for (i = 31; i >= -1; i--) begin
         sclk_pin <= 1'b1;
         half;
         if (i >= 0)
            w[i] = sdo;
         else
            t = sdo;
         sclk_pin <= 1'b0;
         half;
      end
      cs_pin_n <= 1'b1;
      half;
   endtask
endmodule

// ==== asprc_ctrl_sva.sv ====
// Assertions on the ports of the control block
`timescale 1ns/1ps
module asprc_ctrl_sva #(
   parameter DATA_PERIOD = 1024          // Clocks per conversion
) (
   input wire logic        clk,              // Clock
   input wire logic        rst_n,            // Reset
   input wire logic        psel,             // APB
   input wire logic        penable,          // APB
   input wire logic        pwrite,           // APB
   input wire logic [11:0] paddr,            // APB
   input wire logic [31:0] pwdata,           // APB
   input wire logic [31:0] prdata,           // APB
   input wire logic        pready,           // APB
   input wire logic        pslverr,          // APB
   input wire logic        mclk_pin,         // Master clock
   input wire logic        reset_pin_n,      // Reset pin
   input wire logic        power_down_pin_n, // Power-down pin
   input wire logic        align_pin,        // Sync pin
   input wire logic        cs_pin_n,         // Chip select
   input wire logic        sclk_pin,         // Serial clock
   input wire logic        din_pin,          // Serial in
   input wire logic [31:0] conv_data,        // Result in
   input wire logic        dout,             // Serial out
   input wire logic        dout_oe,          // Out enable
   input wire logic        result_ready_n,   // Ready
   input wire logic        core_on,          // Core on
   input wire logic        filter_clear      // Filter clear
);
   logic       sclk_q;
   logic [5:0] fall_cnt_q;
   wire        sfall = sclk_q & ~sclk_pin;
   // Falls of sclk within the current frame, saturating
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q     <= 1'b0;
         fall_cnt_q <= 6'h00;
      end else begin
         sclk_q <= sclk_pin;
         if (cs_pin_n)
            fall_cnt_q <= 6'h00;
         else if (sfall && fall_cnt_q != 6'h3f)
            fall_cnt_q <= fall_cnt_q + 6'h01;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_pd;
      (!power_down_pin_n)[*8] |-> ##2 !core_on;
   endproperty
   a_pd: assert property (p_pd)
      else $error("core on in power-down");
   property p_rst;
      (!reset_pin_n)[*8] |-> ##2 result_ready_n;
   endproperty
   a_rst: assert property (p_rst)
      else $error("ready low in pin reset");
   property p_awake;
      (cs_pin_n && power_down_pin_n && reset_pin_n)[*8] |->
         ##[0:40] core_on;
   endproperty
   a_awake: assert property (p_awake)
      else $error("standby kept with cs high");
   property p_sync;
      $rose(align_pin) |-> ##[1:30] filter_clear;
   endproperty
   a_sync: assert property (p_sync)
      else $error("no filter clear after align");
   property p_rdy;
      sfall && !cs_pin_n |-> ##[1:8] result_ready_n;
   endproperty
   a_rdy: assert property (p_rdy)
      else $error("ready not returned high");
   property p_tail;
      fall_cnt_q >= 6'd33 |-> !dout;
   endproperty
   a_tail: assert property (p_tail)
      else $error("dout not low after word");
   property p_oe_on;
      (!cs_pin_n)[*8] |-> dout_oe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("dout not driven");
   property p_oe_off;
      cs_pin_n[*8] |-> !dout_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("dout driven with cs high");
   property p_ans;
      psel && !penable |=> pready;
   endproperty
   a_ans: assert property (p_ans)
      else $error("no ready in access cycle");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err)
      else $error("error without ready");
   c_rdy: cover property ($fell(result_ready_n));
   c_fc: cover property (filter_clear);
   c_err: cover property (pslverr);
   c_stby: cover property (!core_on && !cs_pin_n);
endmodule
bind asprc_ctrl asprc_ctrl_sva #(.DATA_PERIOD(DATA_PERIOD)) u_sva (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mclk_pin(mclk_pin),
   .reset_pin_n(reset_pin_n), .power_down_pin_n(power_down_pin_n),
   .align_pin(align_pin), .cs_pin_n(cs_pin_n), .sclk_pin(sclk_pin),
   .din_pin(din_pin), .conv_data(conv_data), .dout(dout),
   .dout_oe(dout_oe), .result_ready_n(result_ready_n),
   .core_on(core_on), .filter_clear(filter_clear)
);

// ==== asprc_ctrl_tb.sv ====
// Self-checking bench for the control block
`timescale 1ns/1ps
`include "asprc_consts.vh"
module asprc_ctrl_tb;
   logic        clk, rst_n, psel, penable, pwrite, mclk;
   logic        reset_pin_n, power_down_pin_n, align_pin, err, t;
   logic [11:0] paddr;
   logic [31:0] pwdata, conv_data, rd, w;
   logic [31:0] exp_rst [4] = '{32'h0b, 32'h01, 32'h01, 32'h00};
   wire  [31:0] prdata;
   wire         pready, pslverr, dout, dout_oe, cs_pin_n, sclk_pin;
   wire         din_pin, result_ready_n, core_on, filter_clear;
   integer      errors, total_checks, fc_cnt, i, n;
   always #4 clk = ~clk;
   always #64 mclk = ~mclk;
   asprc_ctrl #(.DATA_PERIOD(32)) dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mclk_pin(mclk),
      .reset_pin_n(reset_pin_n), .power_down_pin_n(power_down_pin_n),
      .align_pin(align_pin), .cs_pin_n(cs_pin_n), .sclk_pin(sclk_pin),
      .din_pin(din_pin), .conv_data(conv_data), .dout(dout),
      .dout_oe(dout_oe), .result_ready_n(result_ready_n),
      .core_on(core_on), .filter_clear(filter_clear));
   asprc_host_model host (
      .clk(clk), .dout(dout), .dout_oe(dout_oe), .cs_pin_n(cs_pin_n),
      .sclk_pin(sclk_pin), .din_pin(din_pin));
   always @(posedge clk)
      if (filter_clear === 1'b1)
         fc_cnt++;
   task test_done;
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_rdy(input integer k);
      repeat (k) begin
         @(posedge clk);
         while (result_ready_n !== 1'b1)
            @(posedge clk);
         while (result_ready_n !== 1'b0)
            @(posedge clk);
      end
   endtask
   initial begin
      #700000;
      errors++;
      test_done;
   end
   initial begin
      {clk, mclk, rst_n, psel, penable, pwrite, align_pin} = 7'h00;
      {reset_pin_n, power_down_pin_n, errors, total_checks, fc_cnt} = 0;
      reset_pin_n = 1'b1;
      power_down_pin_n = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      conv_data = 32'hc3a5_5a3c;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(rd, exp_rst[i]);
      end
      apb(1'b0, 12'h018, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `ASPRC_ADDR_OFC, 32'h029700);
      apb(1'b0, `ASPRC_ADDR_OFC, 32'h0);
      chk(rd, 32'h029700);
      for (i = 0; i < 2; i++) begin
         apb(1'b1, `ASPRC_ADDR_CFG0, {28'h0, 2'b10, {2{i[0]}}});
         apb(1'b1, `ASPRC_ADDR_IDCFG, {31'h0, i[0]});
         apb(1'b0, `ASPRC_ADDR_CFG0, 32'h0);
         chk(rd, {28'h0, 2'b10, {2{i[0]}}});
         apb(1'b0, `ASPRC_ADDR_IDCFG, 32'h0);
         chk(rd, {31'h0, i[0]});
      end
      // Results stay zero while the filter settles after a write
      wait_rdy(2);
      host.read_word(w, t);
      chk(w, 32'h0);
      chk({31'h0, t}, 32'h0);
      wait_rdy(66);
      host.read_word(w, t);
      chk(w, 32'hc3a5_5a3c);
      chk({31'h0, t}, 32'h0);
      for (i = 0; i < 3; i++) begin
         host.send_cmd(i[0] ? `ASPRC_CMD_RESUME : `ASPRC_CMD_STANDBY, 1'b1);
         repeat (10) @(posedge clk);
         chk({31'h0, core_on}, {31'h0, i[0]});
      end
      apb(1'b0, `ASPRC_ADDR_STATUS, 32'h0);
      chk({31'h0, rd[1]}, 32'h1);
      host.release_cs;
      repeat (10) @(posedge clk);
      chk({31'h0, core_on}, 32'h1);
      apb(1'b1, `ASPRC_ADDR_CFG1, 32'h0);
      host.send_cmd(`ASPRC_CMD_RESET, 1'b0);
      repeat (40) @(posedge clk);
      apb(1'b0, `ASPRC_ADDR_CFG1, 32'h0);
      chk(rd, 32'h01);
      // Power-down pin, then reset pin, each held two master clocks
      for (i = 0; i < 2; i++) begin
         apb(1'b1, `ASPRC_ADDR_CFG1, 32'h0);
         @(posedge clk);
         if (i == 0)
            power_down_pin_n <= 1'b0;
         else
            reset_pin_n <= 1'b0;
         repeat (32) @(posedge clk);
         apb(1'b0, `ASPRC_ADDR_CFG1, 32'h0);
         chk(rd, 32'h01);
         power_down_pin_n <= 1'b1;
         reset_pin_n <= 1'b1;
         repeat (20) @(posedge clk);
         apb(1'b1, `ASPRC_ADDR_CFG1, 32'h0);
         apb(1'b0, `ASPRC_ADDR_CFG1, 32'h0);
         chk(rd, 32'h00);
      end
      n = fc_cnt;
      align_pin <= 1'b1;
      repeat (40) @(posedge clk);
      chk(fc_cnt, n + 1);
      align_pin <= 1'b0;
      host.send_cmd(`ASPRC_CMD_SYNC, 1'b0);
      repeat (40) @(posedge clk);
      chk(fc_cnt, n + 2);
      host.send_cmd(`ASPRC_CMD_CMDRD, 1'b1);
      repeat (10) @(posedge clk);
      apb(1'b0, `ASPRC_ADDR_STATUS, 32'h0);
      chk({31'h0, rd[3]}, 32'h0);
      host.send_cmd(`ASPRC_CMD_READ, 1'b0);
      host.send_cmd(`ASPRC_CMD_AUTORD, 1'b0);
      test_done;
   end
endmodule
